// ===== bpw_decoder.sv
// Program word decoder for four mixer bias channels, AXI4-Lite slave.
// Assumes host writes program words over AXI4-Lite; short and cable
// detect come from outside the clock domain.
//
// Implementation choices: the address map and the AXI4-Lite slave port.

module bpw_decoder #(
  parameter logic [15:0] SETTLE_DEFAULT = bpw_pkg::SETTLE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic short_cmd,
  input wire logic cable_present,
  output logic [7:0] pod_lines_0,
  output logic [7:0] pod_lines_1,
  output logic [7:0] pod_lines_2,
  output logic [7:0] pod_lines_3,
  output logic [3:0] open_loop,
  output logic [3:0] internal_bias,
  output logic [3:0] sweep_run,
  output logic [3:0] sweep_zero,
  output logic [1:0] gang_mode,
  output logic [3:0] ext_input_sel,
  output logic [3:0] bias_positive,
  output logic short_opamp,
  output logic short_mixer
);

  typedef struct packed {
    logic [3:0][8:0] ch;
    logic [3:0] sweep_zero;
    logic [1:0] gang;
    logic [15:0] settle;
    logic [15:0] cnt;
    bpw_pkg::bpw_rly_e rly;
    logic [2:0] short_sync;
    logic [2:0] cable_sync;
    logic short_q;
    logic cable_q;
    logic aw_hold;
    logic [7:0] awaddr;
    logic w_hold;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [9:0] last_word;
    // Registered outputs, loaded from the next state so they track the settings
    logic [3:0][7:0] pod;
    logic [3:0] ext_sel;
    logic sh_opamp;
    logic sh_mixer;
  } bpw_state_s;

  bpw_state_s st_r;
  bpw_state_s st_nxt;

  // Pod line pattern from a channel's loop and output state
  function automatic logic [7:0] pod_map(input logic [8:0] c);
    logic [2:0] code;
    code = bpw_pkg::POD_CLOSED;
    if (c[bpw_pkg::OUT_LO +: 2] == bpw_pkg::OUT_GND) begin
      code = bpw_pkg::POD_GND;
    end else if (c[bpw_pkg::OUT_LO +: 2] == bpw_pkg::OUT_ZERO) begin
      code = bpw_pkg::POD_ZERO;
    end else if (c[bpw_pkg::LOOP_BIT]) begin
      code = bpw_pkg::POD_OPEN;
    end
    return 8'h01 << code;
  endfunction

  function automatic logic [3:0] ext_map(input logic [1:0] g);
    logic [3:0] m;
    case (g)
      bpw_pkg::GANG_PAIRS: begin
        m = 4'h5;
      end
      bpw_pkg::GANG_ALL: begin
        m = 4'h1;
      end
      default: begin
        m = 4'hf;
      end
    endcase
    return m;
  endfunction

  logic short_req;
  logic [9:0] pw;
  logic [1:0] sel;
  logic [31:0] rd_word;
  logic do_write;

  always_comb begin
    st_nxt = st_r;
    // Three-stage synchronisers; a change counts when stages two and three agree
    st_nxt.short_sync = {st_r.short_sync[1:0], short_cmd};
    st_nxt.cable_sync = {st_r.cable_sync[1:0], cable_present};
    if (st_r.short_sync[2] == st_r.short_sync[1]) begin
      st_nxt.short_q = st_r.short_sync[2];
    end
    if (st_r.cable_sync[2] == st_r.cable_sync[1]) begin
      st_nxt.cable_q = st_r.cable_sync[2];
    end

    // AXI write channels, taken in either order
    // A pending response blocks both channels: one write at a time
    if (s_axi_awvalid && !st_r.aw_hold && !st_r.bvalid) begin
      st_nxt.aw_hold = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_r.w_hold && !st_r.bvalid) begin
      st_nxt.w_hold = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    do_write = st_r.aw_hold && st_r.w_hold && !st_r.bvalid;
    pw = st_r.wdata[9:0];
    sel = pw[bpw_pkg::ADDR_LO +: 2];
    if (do_write) begin
      st_nxt.aw_hold = 1'b0;
      st_nxt.w_hold = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = 2'h0;
      case (st_r.awaddr)
        bpw_pkg::REG_PROG: begin
          if (st_r.wstrb[0] && st_r.wstrb[1]) begin
            st_nxt.last_word = pw;
            st_nxt.ch[sel][bpw_pkg::LOOP_BIT] = pw[bpw_pkg::LOOP_BIT];
            st_nxt.ch[sel][bpw_pkg::SRC_BIT] = pw[bpw_pkg::SRC_BIT];
            st_nxt.ch[sel][bpw_pkg::SWEEP_BIT] = pw[bpw_pkg::SWEEP_BIT];
            // Sweep on to off zeroes sweep
            if (st_r.ch[sel][bpw_pkg::SWEEP_BIT] && !pw[bpw_pkg::SWEEP_BIT]) begin
              st_nxt.sweep_zero[sel] = 1'b1;
            end else if (pw[bpw_pkg::SWEEP_BIT]) begin
              st_nxt.sweep_zero[sel] = 1'b0;
            end
            if (pw[bpw_pkg::OUT_LO +: 2] != bpw_pkg::OUT_SPARE) begin
              st_nxt.ch[sel][bpw_pkg::OUT_LO +: 2] = pw[bpw_pkg::OUT_LO +: 2];
            end
            if (pw[bpw_pkg::GANG_LO +: 2] != bpw_pkg::GANG_SPARE) begin
              st_nxt.gang = pw[bpw_pkg::GANG_LO +: 2];
            end
          end else begin
            st_nxt.bresp = 2'h2;
          end
        end
        bpw_pkg::REG_SETTLE: begin
          // Takes effect at the next relay step, not the one under way
          if (st_r.wstrb[0]) begin
            st_nxt.settle[7:0] = st_r.wdata[7:0];
          end
          if (st_r.wstrb[1]) begin
            st_nxt.settle[15:8] = st_r.wdata[15:8];
          end
        end
        bpw_pkg::REG_CTRL: begin
          // Write one to clear sweep zero flags
          if (st_r.wstrb[0]) begin
            st_nxt.sweep_zero = st_r.sweep_zero & ~st_r.wdata[3:0];
          end
        end
        default: begin
          st_nxt.bresp = 2'h2;
        end
      endcase
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // AXI read
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      bpw_pkg::REG_PROG: begin
        rd_word = {22'h000000, st_r.last_word};
      end
      bpw_pkg::REG_CTRL: begin
        rd_word = {28'h0000000, st_r.sweep_zero};
      end
      bpw_pkg::REG_STATUS: begin
        // Busy while any relay step is under way
        rd_word = {25'h0, st_r.cable_q, st_r.short_q, st_r.gang,
          st_r.sh_opamp, st_r.sh_mixer, (st_r.rly != bpw_pkg::BPW_RLY_IDLE)};
      end
      bpw_pkg::REG_SETTLE: begin
        rd_word = {16'h0000, st_r.settle};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
    // Channel registers are read-only images of the decoded state
    if (s_axi_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word;
      st_nxt.rresp = 2'h0;
      if (s_axi_araddr >= bpw_pkg::REG_CH0 && s_axi_araddr < 8'h20 &&
          s_axi_araddr[1:0] == 2'h0) begin
        st_nxt.rdata = {23'h000000, st_r.ch[s_axi_araddr[3:2]]};
      end else if (s_axi_araddr > bpw_pkg::REG_SETTLE || s_axi_araddr[1:0] != 2'h0) begin
        st_nxt.rresp = 2'h2;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // Short on command or lost cable
    short_req = st_r.short_q || !st_r.cable_q;
    // Settle count between relay steps
    // A settle of zero still leaves one cycle between steps
    if (st_r.cnt != 16'h0000) begin
      st_nxt.cnt = st_r.cnt - 16'h0001;
    end
    case (st_r.rly)
      bpw_pkg::BPW_RLY_IDLE: begin
        if (short_req) begin
          st_nxt.rly = bpw_pkg::BPW_RLY_OPAMP;
          st_nxt.cnt = st_r.settle;
        end
      end
      bpw_pkg::BPW_RLY_OPAMP: begin
        if (st_r.cnt == 16'h0000) begin
          st_nxt.rly = bpw_pkg::BPW_RLY_FULL;
        end
      end
      bpw_pkg::BPW_RLY_FULL: begin
        if (!short_req) begin
          st_nxt.rly = bpw_pkg::BPW_RLY_RELEASE;
          st_nxt.cnt = st_r.settle;
        end
      end
      bpw_pkg::BPW_RLY_RELEASE: begin
        if (st_r.cnt == 16'h0000) begin
          st_nxt.rly = bpw_pkg::BPW_RLY_IDLE;
        end
      end
      default: begin
        st_nxt.rly = bpw_pkg::BPW_RLY_IDLE;
      end
    endcase

    // Outputs from flip-flops; no decode glitches reach the pods or relays
    for (int i = 0; i < 4; i++) begin
      st_nxt.pod[i] = pod_map(st_nxt.ch[i]);
    end
    st_nxt.ext_sel = ext_map(st_nxt.gang);
    st_nxt.sh_opamp = (st_nxt.rly != bpw_pkg::BPW_RLY_IDLE);
    st_nxt.sh_mixer = (st_nxt.rly == bpw_pkg::BPW_RLY_FULL);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.settle <= SETTLE_DEFAULT;
      st_r.gang <= bpw_pkg::GANG_RESET;
      st_r.cable_sync <= 3'h7;
      // Cable reads present in reset, so no false short at start-up
      st_r.cable_q <= 1'b1;
      st_r.rly <= bpw_pkg::BPW_RLY_IDLE;
      st_r.pod <= {4{pod_map(bpw_pkg::CH_RESET)}};
      st_r.ext_sel <= ext_map(bpw_pkg::GANG_RESET);
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = !st_r.aw_hold && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_hold && !st_r.bvalid;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = !st_r.rvalid;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;

  assign short_opamp = st_r.sh_opamp;
  assign short_mixer = st_r.sh_mixer;

  assign pod_lines_0 = st_r.pod[0];
  assign pod_lines_1 = st_r.pod[1];
  assign pod_lines_2 = st_r.pod[2];
  assign pod_lines_3 = st_r.pod[3];
  assign gang_mode = st_r.gang;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      assign open_loop[gi] = st_r.ch[gi][bpw_pkg::LOOP_BIT];
      assign internal_bias[gi] = st_r.ch[gi][bpw_pkg::SRC_BIT];
      assign sweep_run[gi] = st_r.ch[gi][bpw_pkg::SWEEP_BIT];
      assign sweep_zero[gi] = st_r.sweep_zero[gi];
      assign bias_positive[gi] = 1'b1;
    end
  endgenerate

  assign ext_input_sel = st_r.ext_sel;
endmodule

// ===== bpw_decoder_chk.sv
// Checker for the program word decoder: relay order, pod lines, ganging.
// Assumes a bind onto bpw_decoder, one clock, settle value of one or more.
module bpw_decoder_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] pod_lines_0,
  input wire logic [3:0] sweep_run,
  input wire logic [3:0] sweep_zero,
  input wire logic [1:0] gang_mode,
  input wire logic [3:0] ext_input_sel,
  input wire logic [3:0] bias_positive,
  input wire logic short_opamp,
  input wire logic short_mixer
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  relay_nest_a: assert property (short_mixer |-> short_opamp)
    else $error("mixer short without op-amp short");
  settle_gap_a: assert property ($rose(short_mixer) |-> $past(short_opamp, 2))
    else $error("mixer short too soon");
  unshort_order_a: assert property ($fell(short_opamp) |-> !$past(short_mixer, 2))
    else $error("op-amp released too soon");
  pod_onehot_a: assert property ($onehot(pod_lines_0))
    else $error("pod lines not one state");
  sweep_zeroed_a: assert property ($fell(sweep_run[0]) |-> ##[0:1] sweep_zero[0])
    else $error("sweep not zeroed");
  pairs_ext_a: assert property (gang_mode == bpw_pkg::GANG_PAIRS |->
    ext_input_sel == 4'h5)
    else $error("pairs input mask wrong");
  polarity_pos_a: assert property (bias_positive == 4'hf)
    else $error("polarity not positive");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  cover property ($rose(short_mixer));
  cover property ($fell(short_opamp));
  cover property ($fell(sweep_run[0]));
endmodule
bind bpw_decoder bpw_decoder_chk chk_u (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .pod_lines_0, .sweep_run, .sweep_zero, .gang_mode, .ext_input_sel, .bias_positive,
  .short_opamp, .short_mixer);

// ===== bpw_host.sv
// Host computer model: AXI4-Lite master issuing program words and reads.
// Assumes the caller enters xfer right after a rising clock edge.
module bpw_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr = 8'h00,
  output logic s_axi_awvalid = 1'b0,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic [3:0] s_axi_wstrb = 4'hf,
  output logic s_axi_wvalid = 1'b0,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  output logic [7:0] s_axi_araddr = 8'h00,
  output logic s_axi_arvalid = 1'b0,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  logic hung = 1'b0;
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
    bit aw, w, ar, dn;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (int i = 0; i < 60; i++) begin
      // Sampled mid-cycle: inputs settled until the next edge
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      ar = s_axi_arvalid & s_axi_arready;
      dn = wr ? s_axi_bvalid : s_axi_rvalid;
      r = wr ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (dn) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        return;
      end
    end
    hung = 1'b1;
  endtask
endmodule

// ===== bpw_pkg.sv
// Package for the bias program word decoder: field layout, codes, timing.
// Assumes a single 40 MHz clock domain.
package bpw_pkg;
  localparam int DATA_W = 32;
  localparam logic [7:0] ADDR_W_BITS = 8'h08;
  // Register byte offsets
  localparam logic [7:0] REG_PROG = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_SETTLE = 8'h0c;
  localparam logic [7:0] REG_CH0 = 8'h10;
  // Program word field positions
  localparam int LOOP_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam int SWEEP_BIT = 2;
  localparam int OUT_LO = 3;
  localparam int GANG_LO = 5;
  localparam int ADDR_LO = 7;
  // Output state codes
  localparam logic [1:0] OUT_RUN = 2'h0;
  localparam logic [1:0] OUT_ZERO = 2'h1;
  localparam logic [1:0] OUT_GND = 2'h2;
  localparam logic [1:0] OUT_SPARE = 2'h3;
  // Ganging codes
  localparam logic [1:0] GANG_NONE = 2'h0;
  localparam logic [1:0] GANG_PAIRS = 2'h1;
  localparam logic [1:0] GANG_ALL = 2'h2;
  localparam logic [1:0] GANG_SPARE = 2'h3;
  // Pod state codes
  localparam logic [2:0] POD_GND = 3'h0;
  localparam logic [2:0] POD_ZERO = 3'h1;
  localparam logic [2:0] POD_OPEN = 3'h2;
  localparam logic [2:0] POD_CLOSED = 3'h3;
  // Reset values
  localparam logic [8:0] CH_RESET = 9'h000;
  localparam logic [1:0] GANG_RESET = GANG_NONE;
  // Relay settle time, microseconds, and cycles at 40 MHz
  localparam int SETTLE_US = 5;
  localparam int CLK_MHZ = 40;
  localparam logic [15:0] SETTLE_CYC = 16'(SETTLE_US * CLK_MHZ);
  typedef enum logic [1:0] {BPW_RLY_IDLE, BPW_RLY_OPAMP, BPW_RLY_FULL, BPW_RLY_RELEASE}
    bpw_rly_e;
endpackage

// ===== test_bias_program_word_decoder.sv
// Testbench for the program word decoder: corner and random words, relays.
// Assumes bpw_host as the AXI4-Lite master and a short settle parameter.
module test_bias_program_word_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ST = 16'h0002;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic short_cmd = 1'b0;
  logic cable_present = 1'b1;
  logic [7:0] s_axi_awaddr, s_axi_araddr, pod_lines_0, pod_lines_1, pod_lines_2, pod_lines_3;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb, open_loop, internal_bias, sweep_run, sweep_zero;
  logic [3:0] ext_input_sel, bias_positive;
  logic [1:0] s_axi_bresp, s_axi_rresp, gang_mode, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic short_opamp, short_mixer;
  logic [7:0] pod [4];
  logic [3:0] e_loop = 4'h0, e_src = 4'h0, e_sw = 4'h0, e_sz = 4'h0;
  logic [1:0] e_out [4] = '{default: 2'h0};
  logic [1:0] e_gang = 2'h0;
  logic [8:0] cw [6] = '{9'h08b, 9'h1ff, 9'h1b2, 9'h048, 9'h100, 9'h07a};
  int fails = 0;
  int cmp_count = 0;
  int n;
  always #12.5 aclk = ~aclk;
  assign pod = '{pod_lines_0, pod_lines_1, pod_lines_2, pod_lines_3};
  bpw_decoder #(.SETTLE_DEFAULT(ST)) dut_u (.*);
  bpw_host hst (.*);
  function automatic logic [7:0] pod_exp(logic lp, logic [1:0] o);
    if (o == bpw_pkg::OUT_GND) return 8'h01;
    if (o == bpw_pkg::OUT_ZERO) return 8'h02;
    return lp ? 8'h04 : 8'h08;
  endfunction
  function automatic logic [3:0] ext_exp(logic [1:0] g);
    return g == bpw_pkg::GANG_PAIRS ? 4'h5 : g == bpw_pkg::GANG_ALL ? 4'h1 : 4'hf;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic summarize();
    if (hst.hung) fails++;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic io(input bit wr, input logic [7:0] a, input logic [31:0] d);
    hst.xfer(wr, a, d, q, r);
    if (hst.hung) summarize();
  endtask
  task automatic put(input logic [8:0] w);
    logic [1:0] c;
    c = w[8:7];
    io(1'b1, bpw_pkg::REG_PROG, {23'h0, w});
    chk({30'h0, r}, 32'h0, "prog resp");
    e_sz[c] = w[2] ? 1'b0 : (e_sz[c] | e_sw[c]);
    e_loop[c] = w[0];
    e_src[c] = w[1];
    e_sw[c] = w[2];
    if (w[4:3] != bpw_pkg::OUT_SPARE) e_out[c] = w[4:3];
    if (w[6:5] != bpw_pkg::GANG_SPARE) e_gang = w[6:5];
    @(negedge aclk);
    chk({16'h0, open_loop, internal_bias, sweep_run, sweep_zero},
        {16'h0, e_loop, e_src, e_sw, e_sz}, "channel bits");
    chk({22'h0, gang_mode, ext_input_sel, bias_positive},
        {22'h0, e_gang, ext_exp(e_gang), 4'hf}, "gang");
    for (int i = 0; i < 4; i++)
      chk({24'h0, pod[i]}, {24'h0, pod_exp(e_loop[i], e_out[i])}, "pod");
  endtask
  task automatic waitv(input bit m, input logic v);
    n = 0;
    while ((m ? short_mixer : short_opamp) !== v) begin
      @(negedge aclk);
      n++;
      if (n > 400) begin
        fails++;
        summarize();
      end
    end
  endtask
  initial begin
    void'($urandom(32'h4524f7a4));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (cw[i]) put(cw[i]);
    for (int i = 0; i < 24; i++) put(9'($urandom));
    for (int i = 0; i < 4; i++) begin
      io(1'b0, bpw_pkg::REG_CH0 + 8'(4 * i), 32'h0);
      chk(q, {23'h0, 4'h0, e_out[i], e_sw[i], e_src[i], e_loop[i]}, "channel read");
    end
    io(1'b1, bpw_pkg::REG_CTRL, 32'hf);
    e_sz = 4'h0;
    @(negedge aclk);
    chk({28'h0, sweep_zero}, {28'h0, e_sz}, "sweep zero clear");
    io(1'b1, 8'h40, 32'h0);
    chk({30'h0, r}, 32'h2, "unmapped write");
    io(1'b0, 8'h40, 32'h0);
    chk({30'h0, r}, 32'h2, "unmapped read");
    $display("test words done");
    @(posedge aclk);
    short_cmd <= 1'b1;
    waitv(1'b0, 1'b1);
    waitv(1'b1, 1'b1);
    chk(32'(n), 32'(ST) + 32'h1, "short gap");
    @(posedge aclk);
    short_cmd <= 1'b0;
    waitv(1'b1, 1'b0);
    waitv(1'b0, 1'b0);
    chk(32'(n), 32'(ST) + 32'h1, "unshort gap");
    $display("test relay order done");
    @(posedge aclk);
    cable_present <= 1'b0;
    waitv(1'b1, 1'b1);
    chk({30'h0, short_opamp, short_mixer}, 32'h3, "cable short");
    @(posedge aclk);
    cable_present <= 1'b1;
    waitv(1'b0, 1'b0);
    $display("test cable done");
    summarize();
  end
endmodule
